// File: rtl/sfsw_top.sv
// Status register, write latch and write protection for a serial nonvolatile memory
`timescale 1ns/1ps
module sfsw_top
  import sfsw_pkg::*;
(
  // System clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Serial link from the bus master
  input wire logic sck,
  input wire logic cs_b,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Hardware protect pin
  input wire logic wp_b,
  // Array datapath side
  input wire logic [ADDR_W-1:0] array_addr,
  input wire logic serial_write_done,
  input wire logic waking,
  // Protection results
  output logic array_write_ok,
  output logic [7:0] status_bits
);

  // ----------------------------------------
  // Link side
  // ----------------------------------------

  sfsw_link_if lnk ();

  // Frame reset: chip select high or system reset.
  // Gated reset is the price of a clock that stops between frames.
  logic link_rst_b;
  assign link_rst_b = rst_b & ~cs_b;

  // Counting, phase and output pins live in the shifter
  sfsw_link_shift u_shift (
    .sck(sck),
    .link_rst_b(link_rst_b),
    .si(si),
    .so(so),
    .so_oe(so_oe),
    .lnk(lnk.shifter)
  );

  // Capture registers survive chip select high so the core
  // can read them once the frame has closed.
  sfsw_cap_type cap;
  sfsw_cap_type next_cap;

  // Byte capture at the eighth clock of each field
  always_comb begin
    next_cap = cap;
    // First clock of a new frame forgets the last data byte
    if (lnk.phase == PH_OPCODE && lnk.bit_cnt == CNT_FIRST) begin
      next_cap.data_seen = 1'b0;
    end
    // A toggle, not a flag: a frame with no clocks cannot
    // replay the previous command
    if (lnk.phase == PH_OPCODE && lnk.bit_cnt == CNT_LAST) begin
      next_cap.opcode = {lnk.shift, si};
      next_cap.op_tgl = ~cap.op_tgl;
    end
    // Data byte is only kept for a status write; other
    // opcodes leave input unread
    if (lnk.phase == PH_BYTE && lnk.bit_cnt == CNT_LAST &&
        cap.opcode == OP_WRITE_STATUS) begin
      next_cap.data = {lnk.shift, si};
      next_cap.data_seen = 1'b1;
    end
  end

  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      cap <= '{opcode: '0, op_tgl: 1'b0, data: '0, data_seen: 1'b0};
    end else begin
      cap <= next_cap;
    end
  end

  assign lnk.opcode = cap.opcode;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------

  // Both pins idle high, so reset to high
  logic cs_s;
  logic wp_s;

  sfsw_sync #(
    .W(2),
    .INIT(2'h3)
  ) u_pin_sync (
    .clk(mclk),
    .rst_b(rst_b),
    .d({cs_b, wp_b}),
    .q({cs_s, wp_s})
  );

  // ----------------------------------------
  // Core state
  // ----------------------------------------

  sfsw_core_type core;
  sfsw_core_type next_core;

  // Frame end seen on the system clock
  logic frame_end;
  // A complete opcode arrived in that frame
  logic cmd_done;
  // Status write may change stored bits
  logic status_open;
  // Current stored status as a byte
  logic [7:0] live_status;

  assign frame_end = cs_s & ~core.cs_prev;
  assign cmd_done = frame_end & (cap.op_tgl ^ core.op_tgl);

  // Pin only counts when enabled; latch must be set
  assign status_open = core.latch & ~(core.pin_en & ~wp_s);

  // Busy bit follows the wake-up level only
  assign live_status = sfsw_status_word(core.pin_en, core.guard, core.latch, waking);

  // Command effects, taken at chip select rising.
  // Capture fields are quiet then: the link clock has stopped
  // and the next frame cannot start before the core has read them.
  always_comb begin
    next_core = core;
    next_core.cs_prev = cs_s;

    // Remember which opcode has been acted on
    if (frame_end) begin
      next_core.op_tgl = cap.op_tgl;
    end

    if (cmd_done) begin
      case (cap.opcode)
        OP_SET_LATCH: begin
          next_core.latch = 1'b1;
        end
        OP_CLR_LATCH: begin
          next_core.latch = 1'b0;
        end
        OP_WRITE_STATUS: begin
          // Only pin enable and guards take data; a refusal keeps pin enable and guards
          if (cap.data_seen && status_open) begin
            next_core.pin_en = cap.data[BIT_PIN_EN];
            next_core.guard = {cap.data[BIT_GUARD_HI], cap.data[BIT_GUARD_LO]};
          end
          // Latch never loads from the data byte
          next_core.latch = 1'b0;
        end
        OP_MEM_WRITE, OP_SPECIAL_WRITE: begin
          next_core.latch = 1'b0;
        end
        default: begin
          next_core.latch = core.latch;
        end
      endcase
    end

    // Serial number writes end in the datapath; a set in the
    // same cycle wins over the clear
    if (serial_write_done && !(cmd_done && cap.opcode == OP_SET_LATCH)) begin
      next_core.latch = 1'b0;
    end

    // Link copy only moves between frames, so it is steady
    // while the shifter reads it on the link clock
    if (cs_s) begin
      next_core.view = live_status;
    end

    next_core.status_out = live_status;

    // Protect pin plays no part in array writes
    next_core.write_ok = core.latch & ~sfsw_guarded(core.guard, array_addr);
  end

  // Reset stands in for power-up and factory contents
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      core <= '{
        cs_prev: 1'b1,
        op_tgl: 1'b0,
        latch: LATCH_RESET,
        guard: GUARD_RESET,
        pin_en: PIN_EN_RESET,
        view: STATUS_FIXED,
        status_out: STATUS_FIXED,
        write_ok: 1'b0
      };
    end else begin
      core <= next_core;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // Word handed to the link side
  assign lnk.status_view = core.view;

  // Registered results for the datapath
  assign array_write_ok = core.write_ok;
  assign status_bits = core.status_out;

endmodule

// File: rtl/sfsw_pkg.sv
// Shared constants, types and decode helpers for the status and write-protect block
package sfsw_pkg;

  // ----------------------------------------
  // Command opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;
  localparam logic [7:0] OP_SPECIAL_WRITE = 8'h42;

  // ----------------------------------------
  // Status register layout
  // ----------------------------------------
  localparam int BIT_BUSY = 0;
  localparam int BIT_LATCH = 1;
  localparam int BIT_GUARD_LO = 2;
  localparam int BIT_GUARD_HI = 3;
  localparam int BIT_PIN_EN = 7;
  localparam logic [7:0] STATUS_FIXED = 8'h40;
  localparam logic [1:0] GUARD_RESET = 2'h0;
  localparam logic PIN_EN_RESET = 1'b0;
  localparam logic LATCH_RESET = 1'b0;

  // ----------------------------------------
  // Array protection map
  // ----------------------------------------
  localparam int ADDR_W = 19;
  localparam logic [ADDR_W-1:0] QUARTER_BASE = 19'h60000;
  localparam logic [ADDR_W-1:0] HALF_BASE = 19'h40000;
  localparam logic [1:0] GUARD_NONE = 2'h0;
  localparam logic [1:0] GUARD_QUARTER = 2'h1;
  localparam logic [1:0] GUARD_HALF = 2'h2;
  localparam logic [1:0] GUARD_ALL = 2'h3;

  // ----------------------------------------
  // Serial framing
  // ----------------------------------------
  localparam logic [2:0] CNT_FIRST = 3'h0;
  localparam logic [2:0] CNT_LAST = 3'h7;

  // Gray-coded frame phase: opcode, status byte, anything after
  typedef enum logic [1:0] {
    PH_OPCODE = 2'h0,
    PH_BYTE = 2'h1,
    PH_TAIL = 2'h3
  } sfsw_phase_type;

  // Link shifter state, cleared by chip select high
  typedef struct packed {
    sfsw_phase_type phase;
    logic [2:0] bit_cnt;
    logic [6:0] shift;
  } sfsw_shift_type;

  // Serial output flops, updated on falling clock
  typedef struct packed {
    logic so;
    logic oe;
  } sfsw_out_type;

  // Frame capture held across chip select high
  typedef struct packed {
    logic [7:0] opcode;
    logic op_tgl; // Flips once per complete opcode
    logic [7:0] data;
    logic data_seen;
  } sfsw_cap_type;

  // Core state on the system clock
  typedef struct packed {
    logic cs_prev;
    logic op_tgl; // Last opcode toggle acted on
    logic latch;
    logic [1:0] guard;
    logic pin_en;
    logic [7:0] view;
    logic [7:0] status_out;
    logic write_ok;
  } sfsw_core_type;

  // Is this array address covered by the block-guard code
  function automatic logic sfsw_guarded(input logic [1:0] guard, input logic [ADDR_W-1:0] addr);
    case (guard)
      GUARD_QUARTER: sfsw_guarded = (addr >= QUARTER_BASE);
      GUARD_HALF: sfsw_guarded = (addr >= HALF_BASE);
      GUARD_ALL: sfsw_guarded = 1'b1;
      default: sfsw_guarded = 1'b0;
    endcase
  endfunction

  // Assemble the visible status byte around the fixed bits
  function automatic logic [7:0] sfsw_status_word(input logic pin_en, input logic [1:0] guard,
                                                  input logic latch, input logic busy);
    logic [7:0] w;
    w = STATUS_FIXED;
    w[BIT_PIN_EN] = pin_en;
    w[BIT_GUARD_HI] = guard[1];
    w[BIT_GUARD_LO] = guard[0];
    w[BIT_LATCH] = latch;
    w[BIT_BUSY] = busy;
    sfsw_status_word = w;
  endfunction

endpackage

// File: rtl/sfsw_link_if.sv
// Signals shared between the link shifter and the status core
`timescale 1ns/1ps
interface sfsw_link_if;
  import sfsw_pkg::*;
  sfsw_phase_type phase;
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic [7:0] opcode;
  logic [7:0] status_view;

  modport shifter (output phase, output bit_cnt, output shift, input opcode, input status_view);
  modport core (input phase, input bit_cnt, input shift, output opcode, output status_view);
endinterface

// File: rtl/sfsw_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module sfsw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Destination clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Levels in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } sfsw_sync_type;

  sfsw_sync_type cur;
  sfsw_sync_type next_cur;

  // First stage feeds only the second
  always_comb begin
    next_cur.meta = d;
    next_cur.held = cur.meta;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= {INIT, INIT};
    end else begin
      cur <= next_cur;
    end
  end

  assign q = cur.held;
endmodule

// File: rtl/sfsw_link_shift.sv
// Serial link shifter: bit counting, frame phase and status byte output
`timescale 1ns/1ps
module sfsw_link_shift
  import sfsw_pkg::*;
(
  // Link clock and frame reset
  input wire logic sck,
  input wire logic link_rst_b,
  // Serial pins
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Core side
  sfsw_link_if.shifter lnk
);
  sfsw_shift_type cur;
  sfsw_shift_type next_cur;
  sfsw_out_type out;
  sfsw_out_type next_out;

  // Shift in MSB first, advance phase every eight clocks until the tail
  always_comb begin
    next_cur = cur;
    next_cur.shift = {cur.shift[5:0], si};
    next_cur.bit_cnt = cur.bit_cnt + 3'h1;
    if (cur.bit_cnt == CNT_LAST) begin
      case (cur.phase)
        PH_OPCODE: next_cur.phase = PH_BYTE;
        PH_BYTE: next_cur.phase = PH_TAIL;
        PH_TAIL: next_cur.phase = PH_TAIL;
        default: next_cur.phase = PH_OPCODE;
      endcase
    end
  end

  // Chip select high holds the shifter idle
  always_ff @(posedge sck or negedge link_rst_b) begin
    if (!link_rst_b) begin
      cur <= '{phase: PH_OPCODE, bit_cnt: CNT_FIRST, shift: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // Only the status read drives; any other opcode leaves the pin off
  always_comb begin
    next_out.oe = (cur.phase != PH_OPCODE) && (lnk.opcode == OP_READ_STATUS);
    next_out.so = next_out.oe ? lnk.status_view[CNT_LAST - cur.bit_cnt] : 1'b0;
  end

  // Falling edge output; frame end tristates at once
  always_ff @(negedge sck or negedge link_rst_b) begin
    if (!link_rst_b) begin
      out <= '{so: 1'b0, oe: 1'b0};
    end else begin
      out <= next_out;
    end
  end

  assign lnk.phase = cur.phase;
  assign lnk.bit_cnt = cur.bit_cnt;
  assign lnk.shift = cur.shift;
  assign so = out.so;
  assign so_oe = out.oe;
endmodule

// File: verification/sfsw_top_asserts.sv
// Concurrent checks on the ports of the status and write-protect block
`timescale 1ns/1ps
module sfsw_top_asserts
  import sfsw_pkg::*;
(
  // System clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Serial link
  input wire logic sck,
  input wire logic cs_b,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  // Protect pin and datapath
  input wire logic wp_b,
  input wire logic [ADDR_W-1:0] array_addr,
  input wire logic serial_write_done,
  input wire logic waking,
  input wire logic array_write_ok,
  input wire logic [7:0] status_bits
);
  // ----------------------------------------
  // Status and protection relations
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  fixed_bits_a: assert property (status_bits[6:4] == 3'h4) else $error("fixed status bits wrong");
  latch_power_a: assert property ($rose(rst_b) |-> !status_bits[1]) else $error("latch set at power-up");
  // Latch may only rise once a frame has ended
  latch_frame_a: assert property ($rose(status_bits[1]) |-> cs_b) else $error("latch set inside frame");
  guard_update_a: assert property ($changed({status_bits[7], status_bits[3:2]}) |-> $past(status_bits[1]))
    else $error("status written without latch");
  write_ok_latch_a: assert property (array_write_ok |-> status_bits[1] || $past(status_bits[1]))
    else $error("array write allowed without latch");
  // Guard must have held over the whole pipeline before the figure counts
  guard_all_a: assert property (status_bits[3:2] == 2'h3 && $past(status_bits[3:2], 2) == 2'h3 |->
    !array_write_ok) else $error("write allowed under full guard");
  guard_half_a: assert property (status_bits[3:2] == 2'h2 && $past(status_bits[3:2], 2) == 2'h2 &&
    $past(array_addr) >= 19'h40000 |-> !array_write_ok) else $error("write allowed in guarded half");
  so_quiet_a: assert property (cs_b |-> !so_oe && !so) else $error("output driven while deselected");
  busy_idle_a: assert property (!$past(waking) && !$past(waking, 2) |-> !status_bits[0])
    else $error("busy bit set while awake");
endmodule

bind sfsw_top sfsw_top_asserts i_chk (.mclk(mclk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si), .so(so),
  .so_oe(so_oe), .wp_b(wp_b), .array_addr(array_addr), .serial_write_done(serial_write_done),
  .waking(waking), .array_write_ok(array_write_ok), .status_bits(status_bits));

// File: verification/sfsw_spi_master.sv
// Mode 0 and mode 3 serial bus master model for the status block
`timescale 1ns/1ps
module sfsw_spi_master (
  // Serial link
  output logic sck,
  output logic cs_b,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  // Mode 3 parks the clock high between frames
  logic idle_hi = 1'b0;

  // Idle bus: clock parked low, device deselected
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    si = 1'b1;
  end

  // One frame: opcode then nd bits of dat, MSB first; 64 ns link clock only inside the frame
  task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input int nd,
                      output logic [7:0] rd, output logic oe_seen);
    logic [15:0] w;
    w = {op, dat};
    rd = 8'h00;
    oe_seen = 1'b0;
    sck = idle_hi; // Park at the idle level of the chosen mode
    #19 cs_b = 1'b0;
    if (idle_hi) begin
      #16 sck = 1'b0; // Mode 3 opens with a falling edge
    end
    for (int i = 0; i < 8 + nd; i++) begin
      #16 si = w[15 - i];
      #16 sck = 1'b1;
      if (i >= 8) begin
        rd = {rd[6:0], so};
      end
      oe_seen = oe_seen | so_oe;
      #32 sck = idle_hi && (i == 7 + nd); // Mode 3 stays high after the last bit
    end
    #16 cs_b = 1'b1;
    si = ~si; // Released line must not keep its last level
    #100;
  endtask
endmodule

// File: verification/tb_sfsw_top.sv
// Self-checking testbench for the status and write-protect block
`timescale 1ns/1ps
module tb_sfsw_top;
  import sfsw_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic mclk = 1'b0;
  logic rst_b = 1'b1;
  logic wp_b = 1'b1;
  logic [ADDR_W-1:0] array_addr = '0;
  logic serial_write_done = 1'b0;
  logic waking = 1'b0;
  logic sck, cs_b, si, so, so_oe, array_write_ok, oe, e;
  logic [7:0] status_bits, rd;
  logic [1:0] g;
  logic [ADDR_W-1:0] al [5] = '{19'h00000, 19'h3FFFF, 19'h40000, 19'h5FFFF, 19'h60000};
  logic [7:0] cl [2] = '{OP_MEM_WRITE, OP_SPECIAL_WRITE};
  int err_count = 0;
  int checks = 0;
  int cycles = 0;

  always #2.5 mclk = ~mclk;

  sfsw_top i_dut (.mclk(mclk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si), .so(so), .so_oe(so_oe),
    .wp_b(wp_b), .array_addr(array_addr), .serial_write_done(serial_write_done), .waking(waking),
    .array_write_ok(array_write_ok), .status_bits(status_bits));
  sfsw_spi_master i_master (.sck(sck), .cs_b(cs_b), .si(si), .so(so), .so_oe(so_oe));

  // Verdict and end of run
  task automatic conclude();
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Compare one value
  task automatic expect8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Let edges pass, then step off the edge so outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Status write behind its own set-latch frame
  task automatic wr_status(input logic [7:0] d, input int nd);
    i_master.xfer(OP_SET_LATCH, 8'h00, 0, rd, oe);
    i_master.xfer(OP_WRITE_STATUS, d, nd, rd, oe);
  endtask
  // Read status over the link and compare both views
  task automatic chk_status(input logic [7:0] exp);
    i_master.xfer(OP_READ_STATUS, 8'h00, 8, rd, oe);
    tick(2);
    expect8(rd, exp);
    expect8({7'h00, oe}, 8'h01);
    expect8(status_bits, exp);
  endtask
  // Array write permission at one address
  task automatic chk_addr(input logic [ADDR_W-1:0] a, input logic exp);
    @(posedge mclk) array_addr <= a;
    tick(3);
    expect8({7'h00, array_write_ok}, {7'h00, exp});
  endtask

  // Hang guard, sized well above the roughly ten thousand cycles the sequence needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      conclude();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b <= 1'b0; // Gives the asynchronous resets a real falling edge
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    tick(4);
    expect8(status_bits, 8'h40);
    chk_addr(19'h00000, 1'b0);
    chk_status(8'h40);
    i_master.xfer(OP_WRITE_STATUS, 8'hFF, 8, rd, oe);
    chk_status(8'h40);
    i_master.xfer(OP_SET_LATCH, 8'h00, 0, rd, oe);
    chk_status(8'h42);
    // Same read with the clock parked high between frames
    i_master.idle_hi = 1'b1;
    chk_status(8'h42);
    i_master.idle_hi = 1'b0;
    i_master.xfer(OP_CLR_LATCH, 8'h00, 0, rd, oe);
    chk_status(8'h40);
    // Every guard code; data sets fixed bits and bit 1 that must not stick
    for (int k = 0; k < 4; k++) begin
      g = k[1:0];
      wr_status({4'h3, g, 2'h3}, 8);
      chk_status({4'h4, g, 2'h0});
      i_master.xfer(OP_SET_LATCH, 8'h00, 0, rd, oe);
      foreach (al[j]) begin
        e = (g == GUARD_NONE) || (g == GUARD_QUARTER && al[j] < QUARTER_BASE) ||
            (g == GUARD_HALF && al[j] < HALF_BASE);
        chk_addr(al[j], e);
      end
      chk_addr(19'h7FFFF, g == GUARD_NONE);
      i_master.xfer(OP_CLR_LATCH, 8'h00, 0, rd, oe);
      chk_addr(19'h00000, 1'b0);
    end
    // Protect pin low: ignored until the pin enable is set
    @(posedge mclk) wp_b <= 1'b0;
    wr_status(8'h80, 8);
    chk_status(8'hC0);
    wr_status(8'h8C, 8);
    chk_status(8'hC0);
    i_master.xfer(OP_SET_LATCH, 8'h00, 0, rd, oe);
    chk_addr(19'h7FFFF, 1'b1);
    @(posedge mclk) wp_b <= 1'b1;
    wr_status(8'h00, 8);
    chk_status(8'h40);
    // Cut data byte whose leading bits would set the pin enable
    wr_status(8'hCC, 4);
    chk_status(8'h40);
    // Other write frames and the serial-number pulse drop the latch
    foreach (cl[j]) begin
      i_master.xfer(OP_SET_LATCH, 8'h00, 0, rd, oe);
      i_master.xfer(cl[j], 8'h00, 8, rd, oe);
      chk_status(8'h40);
    end
    i_master.xfer(OP_SET_LATCH, 8'h00, 0, rd, oe);
    @(posedge mclk) serial_write_done <= 1'b1;
    @(posedge mclk) serial_write_done <= 1'b0;
    chk_status(8'h40);
    i_master.xfer(8'h9F, 8'h00, 8, rd, oe);
    expect8({7'h00, oe}, 8'h00);
    @(posedge mclk) waking <= 1'b1;
    tick(3);
    chk_status(8'h41);
    @(posedge mclk) waking <= 1'b0;
    // Second power-up with the latch set
    i_master.xfer(OP_SET_LATCH, 8'h00, 0, rd, oe);
    expect8(status_bits, 8'h42);
    @(posedge mclk) rst_b <= 1'b0;
    tick(2);
    @(posedge mclk) rst_b <= 1'b1;
    tick(4);
    expect8(status_bits, 8'h40);
    conclude();
  end
endmodule
